// >>> design/pss_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// RULE1 - stage one drives its programmed supply settings
// RULE2 - stage one lasts two to field cycles
// RULE3 - bit 14 stops processor tile clock
// RULE4 - bit 9 picks analog converter modulation
// RULE5 - bit 8 picks core converter modulation
// RULE6 - bit 5 enables io supply output
// RULE7 - bit 4 enables pll linear regulator
// RULE8 - bit 0 enables core buck converter
// RULE9 - bit 1 analog converter reads one, fixed
// RULE10 - status shows current sequencer state code
// RULE11 - status bits 29,28 show previous io,pll
// RULE12 - status bits 25,24 show previous converters
// RULE13 - status low fields mirror applied settings
// RULE14 - dwell counts ticks of enabled clock
// RULE15 - leave asleep after dwell and wake
// RULE16 - reserved and read-only bits ignore writes
// RULE17 - stage one expiry moves to stage two
module pss_ctrl #(
    parameter int SLOW_DIV = pss_pkg::SLOW_DIV
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // asynchronous requests
    input  wire logic        sleep_req,
    input  wire logic        wake_pin,
    input  wire logic        rtc_match,
    input  wire logic        slow_clk_sel,
    // supply controls
    output logic             core_buck_converter_en,
    output logic             analog_buck_converter_en,
    output logic             io_supply_output_en,
    output logic             pll_linear_regulator_en,
    output logic             core_buck_pfm,
    output logic             analog_buck_pfm,
    output logic             tile_clk_stop
);
    generate
        if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin : g_chk
            $error("SLOW_DIV out of range");
        end
    endgenerate

    // input synchronisers, one flop pair per pin
    wire  [3:0] sync_w;
    wire  [3:0] raw_in = {slow_clk_sel, rtc_match, wake_pin, sleep_req};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= raw_in[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_w[gi] = sync_q;
        end
    endgenerate
    wire sleep_s = sync_w[0];
    wire wake_s  = sync_w[1] | sync_w[2];
    wire slow_s  = sync_w[3];

    // slow clock enable
    logic [15:0] div_q;
    wire         tick = slow_s ? (div_q == 16'h0) : 1'b1; // [RULE14]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 16'h0;
        end else if (!slow_s || div_q == 16'h0) begin
            div_q <= 16'(SLOW_DIV - 1);
        end else begin
            div_q <= div_q - 16'h1;
        end
    end

    // registers
    logic [31:0] slp1_q;
    logic [31:0] slp2_q;
    logic [31:0] conv_q;
    logic [15:0] appl_q;
    logic [3:0]  prev_q;
    pss_pkg::pss_state_t state_q;
    pss_pkg::pss_state_t state_d;

    // write channel
    logic        aw_q;
    logic        w_q;
    logic [7:0]  wa_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    wire         aw_hs = awvalid & awready;
    wire         w_hs  = wvalid & wready;
    wire         do_wr = aw_q & w_q;
    wire [31:0]  bmask = {{8{ws_q[3]}}, {8{ws_q[2]}},
                          {8{ws_q[1]}}, {8{ws_q[0]}}};
    wire         hit_1 = wa_q == pss_pkg::A_SLP1;
    wire         hit_2 = wa_q == pss_pkg::A_SLP2;
    wire         hit_c = wa_q == pss_pkg::A_CONV;
    wire         hit_s = wa_q == pss_pkg::A_STAT;
    wire         wr_ok = hit_1 | hit_2 | hit_c | hit_s;
    wire [31:0]  cm    = bmask & pss_pkg::CFG_WMASK; // [RULE16]
    wire [31:0]  vm    = bmask & pss_pkg::CONV_MASK;
    wire [31:0]  slp1_w = (slp1_q & ~cm) | (wd_q & cm);
    wire [31:0]  slp2_w = (slp2_q & ~cm) | (wd_q & cm);
    wire [31:0]  conv_w = (conv_q & ~vm) | (wd_q & vm);

    assign awready = ~aw_q & ~bvalid_q;
    assign wready  = ~w_q & ~bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            wa_q <= 8'h0;
        end else if (aw_hs) begin
            aw_q <= 1'b1;
            wa_q <= awaddr;
        end else if (do_wr) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q  <= 1'b0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
        end else if (w_hs) begin
            w_q  <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
        end else if (do_wr) begin
            w_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= pss_pkg::RESP_OK;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? pss_pkg::RESP_OK : pss_pkg::RESP_ERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slp1_q <= pss_pkg::SLP_RST;
            slp2_q <= pss_pkg::SLP_RST;
            conv_q <= 32'h0;
        end else if (do_wr) begin
            if (hit_1) slp1_q <= slp1_w;
            if (hit_2) slp2_q <= slp2_w;
            if (hit_c) conv_q <= conv_w;
        end
    end

    // read channel
    wire [31:0] slp1_r = slp1_q | pss_pkg::CFG_RO1; // [RULE9]
    wire [31:0] slp2_r = slp2_q | pss_pkg::CFG_RO1;
    wire [31:0] stat_r = {2'h0, prev_q[3:2], 2'h0, prev_q[1:0], // [RULE11] [RULE12]
                          5'h0, state_q, appl_q}; // [RULE10] [RULE13]
    wire        rd_1 = araddr == pss_pkg::A_SLP1;
    wire        rd_2 = araddr == pss_pkg::A_SLP2;
    wire        rd_s = araddr == pss_pkg::A_STAT;
    wire        rd_c = araddr == pss_pkg::A_CONV;
    wire        rd_ok = rd_1 | rd_2 | rd_s | rd_c;
    wire [31:0] rd_mux = rd_1 ? slp1_r :
                         rd_2 ? slp2_r :
                         rd_s ? stat_r :
                         rd_c ? conv_q : 32'h0;
    logic       rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign arready = ~rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= pss_pkg::RESP_OK;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? pss_pkg::RESP_OK : pss_pkg::RESP_ERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // dwell counter
    logic [31:0] cnt_q;
    logic [4:0]  dwell_n;
    always_comb begin
        case (state_q)
            pss_pkg::ST_SLP1:   dwell_n = slp1_q[pss_pkg::DWELL_LSB +: 5];
            pss_pkg::ST_SLP2:   dwell_n = slp2_q[pss_pkg::DWELL_LSB +: 5];
            pss_pkg::ST_ASLEEP: dwell_n = pss_pkg::ASLEEP_LOG2;
            default:            dwell_n = 5'h0;
        endcase
    end
    wire [31:0] limit = (32'h1 << dwell_n) - 32'h1; // [RULE2]
    wire        dwell_done = tick && (cnt_q >= limit); // [RULE2] [RULE14]
    wire        st_chg = state_d != state_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || st_chg) begin
            cnt_q <= 32'h0;
        end else if (tick && cnt_q != 32'hffffffff) begin
            // saturate so a long stay asleep never wraps below the minimum
            cnt_q <= cnt_q + 32'h1; // [RULE14]
        end
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            pss_pkg::ST_RESET:  state_d = pss_pkg::ST_AWAIT;
            pss_pkg::ST_AWAIT:  if (tick) state_d = pss_pkg::ST_AWAKE;
            pss_pkg::ST_AWAKE:  if (sleep_s) state_d = pss_pkg::ST_SLP1;
            pss_pkg::ST_SLP1:   if (dwell_done) state_d = pss_pkg::ST_SLP2; // [RULE17]
            pss_pkg::ST_SLP2:   if (dwell_done) state_d = pss_pkg::ST_ASLEEP;
            pss_pkg::ST_ASLEEP: if (dwell_done && wake_s) state_d = pss_pkg::ST_WAKE1; // [RULE15]
            pss_pkg::ST_WAKE1:  if (tick) state_d = pss_pkg::ST_WAKE2;
            pss_pkg::ST_WAKE2:  if (tick) state_d = pss_pkg::ST_AWAIT;
            default:            state_d = pss_pkg::ST_RESET;
        endcase
    end

    // settings applied for the current state
    logic [15:0] appl_d;
    always_comb begin
        case (state_q)
            pss_pkg::ST_SLP1:   appl_d = slp1_r[15:0]; // [RULE1]
            pss_pkg::ST_SLP2,
            pss_pkg::ST_ASLEEP: appl_d = slp2_r[15:0];
            default:            appl_d = pss_pkg::AWAKE_SET;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= pss_pkg::ST_RESET;
            appl_q  <= pss_pkg::AWAKE_SET;
            prev_q  <= pss_pkg::PREV_RST;
        end else begin
            state_q <= state_d;
            appl_q  <= appl_d;
            if (st_chg) prev_q <= {appl_d[pss_pkg::IO_B], appl_d[pss_pkg::PLL_B], // [RULE11]
                                   appl_d[pss_pkg::AEN_B], appl_d[pss_pkg::CEN_B]}; // [RULE12]
        end
    end

    assign core_buck_converter_en   = appl_q[pss_pkg::CEN_B];   // [RULE8]
    assign analog_buck_converter_en = appl_q[pss_pkg::AEN_B];   // [RULE9]
    assign io_supply_output_en      = appl_q[pss_pkg::IO_B];    // [RULE6]
    assign pll_linear_regulator_en  = appl_q[pss_pkg::PLL_B];   // [RULE7]
    assign core_buck_pfm            = appl_q[pss_pkg::CPFM_B];  // [RULE5]
    assign analog_buck_pfm          = appl_q[pss_pkg::APFM_B];  // [RULE4]
    assign tile_clk_stop            = appl_q[pss_pkg::GATE_B];  // [RULE3]

    // checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_s1_supplies: assert property ( // [RULE1]
        state_q == pss_pkg::ST_SLP1 |=> {io_supply_output_en, pll_linear_regulator_en,
            core_buck_converter_en} == {$past(slp1_q[5]), $past(slp1_q[4]), $past(slp1_q[0])})
        else $error("stage one supplies wrong");
    a_s1_gate: assert property ( // [RULE3]
        state_q == pss_pkg::ST_SLP1 |=> tile_clk_stop == $past(slp1_q[14]))
        else $error("tile clock gate wrong");
    a_s1_mod: assert property ( // [RULE4]
        state_q == pss_pkg::ST_SLP1 |=> {analog_buck_pfm, core_buck_pfm} == $past(slp1_q[9:8]))
        else $error("modulation wrong");
    a_analog_on: assert property ( // [RULE9]
        state_q == pss_pkg::ST_SLP1 |=> analog_buck_converter_en)
        else $error("analog converter off");
    a_dwell_hold: assert property ( // [RULE2]
        state_q == pss_pkg::ST_SLP1 && !dwell_done |=> state_q == pss_pkg::ST_SLP1)
        else $error("stage one left early");
    a_dwell_exit: assert property ( // [RULE17]
        state_q == pss_pkg::ST_SLP1 && dwell_done |=> state_q == pss_pkg::ST_SLP2)
        else $error("stage one not left");
    a_wake_gate: assert property ( // [RULE15]
        state_q == pss_pkg::ST_ASLEEP && !(dwell_done && wake_s) |=> state_q == pss_pkg::ST_ASLEEP)
        else $error("woke without cause");
    a_stat_read: assert property ( // [RULE10]
        arvalid && arready && rd_s |=> rdata[18:16] == $past(state_q) && rdata[15:0] == $past(appl_q))
        else $error("status read wrong");
    a_prev_track: assert property ( // [RULE11]
        st_chg |=> prev_q == {$past(appl_d[5]), $past(appl_d[4]), $past(appl_d[1]), $past(appl_d[0])})
        else $error("previous supplies wrong");
    a_slow_tick: assert property ( // [RULE14]
        slow_s && $past(slow_s) && tick |=> !tick)
        else $error("slow tick too fast");

    c_s1_to_s2: cover property (state_q == pss_pkg::ST_SLP1 ##1 state_q == pss_pkg::ST_SLP2);
    c_wake: cover property (state_q == pss_pkg::ST_ASLEEP ##1 state_q == pss_pkg::ST_WAKE1);
    c_write: cover property (do_wr && hit_1);
    c_s2_to_asleep: cover property (state_q == pss_pkg::ST_SLP2 ##1 state_q == pss_pkg::ST_ASLEEP);
endmodule

`default_nettype wire

// >>> design/pss_pkg.sv
package pss_pkg;
    // register byte offsets
    localparam logic [7:0] A_SLP1 = 8'h1c;
    localparam logic [7:0] A_SLP2 = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    localparam logic [7:0] A_CONV = 8'h2c;
    // stage configuration layout
    localparam logic [31:0] CFG_WMASK = 32'h001f4331;
    localparam logic [31:0] CFG_RO1   = 32'h00000002;
    localparam logic [31:0] SLP_RST   = 32'h00100000;
    localparam logic [31:0] CONV_MASK = 32'h000000ff;
    localparam logic [15:0] AWAKE_SET = 16'h0033;
    localparam int DWELL_LSB = 16;
    localparam int GATE_B    = 14;
    localparam int APFM_B    = 9;
    localparam int CPFM_B    = 8;
    localparam int IO_B      = 5;
    localparam int PLL_B     = 4;
    localparam int AEN_B     = 1;
    localparam int CEN_B     = 0;
    // status layout
    localparam int ST_LSB  = 16;
    localparam int PREV_LO = 24;
    localparam logic [3:0] PREV_RST = 4'h2;
    // timing
    localparam int CLK_HZ   = 100_000_000;
    localparam int SLOW_HZ  = 31_000;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam logic [4:0] ASLEEP_LOG2 = 5'h04;
    // bus answers
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RESET  = 3'h0,
        ST_ASLEEP = 3'h1,
        ST_WAKE1  = 3'h2,
        ST_WAKE2  = 3'h3,
        ST_AWAIT  = 3'h4,
        ST_AWAKE  = 3'h5,
        ST_SLP1   = 3'h6,
        ST_SLP2   = 3'h7
    } pss_state_t;
endpackage

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        sleep_req = 1'b0, wake_pin = 1'b0, rtc_match = 1'b0, slow_clk_sel = 1'b0;
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic   cen, aen, io_en, pll_en, cpfm, apfm, stop;
    wire logic [6:0] outs = {stop, apfm, cpfm, io_en, pll_en, aen, cen};
    int          n_errors = 0;
    int          checked = 0;
    int          seed = 32'hd3a1;
    int          cyc = 0;
    logic [6:0]  o_s;

    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    pss_ctrl #(.SLOW_DIV(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sleep_req(sleep_req),
        .wake_pin(wake_pin), .rtc_match(rtc_match), .slow_clk_sel(slow_clk_sel),
        .core_buck_converter_en(cen), .analog_buck_converter_en(aen), .io_supply_output_en(io_en),
        .pll_linear_regulator_en(pll_en), .core_buck_pfm(cpfm), .analog_buck_pfm(apfm),
        .tile_clk_stop(stop)
    );

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("wrong value at %0t: no answer for %s", $time, what);
        stop_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int  k;
        logic ta, tw, tb;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        tb = 1'b0;
        for (k = 0; k < 100 && !tb; k++) begin
            #1;
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge aclk);
        if (!tb) hang("write");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int  k;
        logic ta, tr;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        tr = 1'b0;
        for (k = 0; k < 100 && !tr; k++) begin
            #1;
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge aclk);
        if (!tr) hang("read");
    endtask

    task automatic wait_stop(input logic v, output int t);
        int k;
        for (k = 0; k < 2000 && stop !== v; k++) begin
            @(posedge aclk);
            #1;
        end
        t = cyc;
        o_s = outs;
        @(posedge aclk);
        if (k == 2000) hang("clock stop change");
    endtask

    task automatic wait_awake;
        logic [31:0] r;
        logic [1:0]  e;
        int          k;
        r = 32'h0;
        for (k = 0; k < 80 && r[18:16] !== 3'h5; k++) rd(pss_pkg::A_STAT, r, e);
        if (k == 80) hang("awake state");
    endtask

    function automatic logic [31:0] cfg_exp(input logic [31:0] c);
        return (c & pss_pkg::CFG_WMASK) | pss_pkg::CFG_RO1;
    endfunction

    function automatic logic [6:0] out_exp(input logic [31:0] c);
        return {c[14], c[9], c[8], c[5], c[4], 1'b1, c[0]};
    endfunction

    function automatic logic [31:0] st_exp(input logic [31:0] p, input logic [2:0] s, input logic [31:0] c);
        return {2'h0, p[5:4], 2'h0, 1'b1, p[0], 5'h0, s, (c[15:0] & 16'h4331) | 16'h0002};
    endfunction

    initial begin
        logic [31:0] c1, c2, v, r, aw;
        logic [1:0]  e;
        int          n, t0, t1, lo, hi, rnd;
        aw = 32'(pss_pkg::AWAKE_SET);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wait_awake();
        rd(pss_pkg::A_STAT, r, e);
        chk(r, st_exp(aw, 3'h5, aw), "status after reset");
        rd(pss_pkg::A_SLP1, r, e);
        chk(r, 32'h00100002, "stage one reset");
        rd(8'h28, r, e);
        chk(r, 32'h0, "unmapped read data");
        chk(32'(e), 32'(pss_pkg::RESP_ERR), "unmapped read response");
        wr(8'h28, $random(seed), e);
        chk(32'(e), 32'(pss_pkg::RESP_ERR), "unmapped write");
        wr(pss_pkg::A_STAT, $random(seed), e);
        rd(pss_pkg::A_STAT, r, e);
        chk(r, st_exp(aw, 3'h5, aw), "status after write");
        v = $random(seed);
        wr(pss_pkg::A_CONV, v, e);
        rd(pss_pkg::A_CONV, r, e);
        chk(r, v & pss_pkg::CONV_MASK, "converter control");
        for (rnd = 0; rnd < 4; rnd++) begin
            n = 3 + rnd;
            c1 = ($random(seed) & ~32'h001f0000) | (32'(n) << 16) | 32'h00004000;
            c2 = $random(seed) & ~32'h001f4000;
            slow_clk_sel <= (rnd == 3);
            wr(pss_pkg::A_SLP1, c1, e);
            wr(pss_pkg::A_SLP2, c2, e);
            rd(pss_pkg::A_SLP1, r, e);
            chk(r, cfg_exp(c1), "stage one readback");
            sleep_req <= 1'b1;
            wait_stop(1'b1, t0);
            sleep_req <= 1'b0;
            chk(32'(o_s), 32'(out_exp(c1)), "stage one outputs");
            rd(pss_pkg::A_STAT, r, e);
            chk(r, st_exp(aw, 3'h6, c1), "stage one status");
            wait_stop(1'b0, t1);
            hi = (1 << n) * ((rnd == 3) ? 4 : 1);
            lo = (rnd == 3) ? hi - 3 : hi;
            chk(32'(t1 - t0 >= lo && t1 - t0 <= hi), 32'h1, "stage one dwell");
            repeat (8) @(posedge aclk);
            rd(pss_pkg::A_STAT, r, e);
            chk(r, st_exp(c2, 3'h1, c2), "asleep status");
            chk(32'(outs), 32'(out_exp(c2)), "asleep outputs");
            repeat (100) @(posedge aclk);
            rd(pss_pkg::A_STAT, r, e);
            chk(32'(r[18:16]), 32'h1, "asleep without wake");
            if (rnd % 2 == 1) wake_pin <= 1'b1;
            else rtc_match <= 1'b1;
            wait_awake();
            wake_pin <= 1'b0;
            rtc_match <= 1'b0;
            rd(pss_pkg::A_STAT, r, e);
            chk(r, st_exp(aw, 3'h5, aw), "awake again");
        end
        stop_test();
    end
endmodule

`default_nettype wire
